// ===== core/tov_regs.vh
/*
 * Register map, field positions, reset values and timing constants of the
 * thermal overload alarm and trip decision block.
 * Assumes a 32-bit classic Wishbone slave port and a 200 MHz system clock.
 */
// How it works
// R1 - alarm 1 follows capacity versus its 0.1 % threshold only when enabled, default 40 %
// R2 - alarm 2 has its own enable and threshold, default 40 %
// R3 - restart inhibit has its own enable and threshold, default 80 %
// R4 - trip asserts at trip threshold (100 %) after extra delay in 5 ms steps
// R5 - blocking input is sampled once at the start of each program cycle
// R6 - pick-up with blocking inactive gives start and runs the operate delay
// R7 - pick-up while blocked gives a blocked indication and nothing else
// R8 - blocking after start clears start and releases like a pick-up drop-out
// R9 - the blocking source must arrive at least 5 ms before the delay expires
// R10 - condition code normal, alarm 1, alarm 2, inhibit, trip or blocked
// R11 - load class from current: light, normal, overloading, high overload
// R12 - bad service factor is replaced by 1.0 with a fault flag while bad
// R13 - bad ambient settings give correction 1.0 and an ambient fault flag
// R14 - bad nominal current setting is replaced by 1.0 with its fault flag
// R15 - inconsistent ambient k settings raise their own fault flag
// R16 - node behaviour on, blocked, test, test/blocked, off shown only when allowed
// R17 - resettable counters of alarm 1, alarm 2, inhibit, trip and blocked trips
// R18 - on and off events per output, stored as selected: on, off or both
// R19 - comparisons assert at capacity >= setting and release below it
`ifndef TOV_REGS_VH
`define TOV_REGS_VH

`define TOV_ADR_CTRL 8'h00
`define TOV_ADR_A1_LVL 8'h04
`define TOV_ADR_A2_LVL 8'h08
`define TOV_ADR_INH_LVL 8'h0C
`define TOV_ADR_TRIP_LVL 8'h10
`define TOV_ADR_TRIP_DLY 8'h14
`define TOV_ADR_STATUS 8'h18
`define TOV_ADR_IRQ_STAT 8'h1C
`define TOV_ADR_IRQ_MASK 8'h20
`define TOV_ADR_CNT_CLR 8'h24
`define TOV_ADR_CNT_BASE 8'h28
`define TOV_ADR_TSTAMP 8'h3C

// control register fields
`define TOV_CTRL_EN_A1 0
`define TOV_CTRL_EN_A2 1
`define TOV_CTRL_EN_INH 2
`define TOV_CTRL_ALLOW_NODE 3
`define TOV_CTRL_MODE_LO 4
`define TOV_CTRL_MODE_HI 5
`define TOV_CTRL_EVT_ON 8
`define TOV_CTRL_EVT_OFF 9
`define TOV_CTRL_RST 32'h0000_0300

// thresholds in 0.1 % units, delay in 5 ms steps
`define TOV_A1_LVL_RST 12'h190
`define TOV_A2_LVL_RST 12'h190
`define TOV_INH_LVL_RST 12'h320
`define TOV_TRIP_LVL_RST 12'h3E8
`define TOV_TRIP_DLY_RST 20'h0_0000
`define TOV_TRIP_DLY_MAX 20'hA_FC80

// per-unit values in 0.01 steps
`define TOV_UNITY 16'h0064
`define TOV_LIGHT_LOAD 16'h0001
`define TOV_HIGH_LOAD 16'h00C8

// program cycle length
`define TOV_CYCLE_NS 5000000
`define TOV_CLK_PERIOD_NS 5

// condition codes
`define TOV_COND_NORMAL 3'h0
`define TOV_COND_A1 3'h1
`define TOV_COND_A2 3'h2
`define TOV_COND_INH 3'h3
`define TOV_COND_TRIP 3'h4
`define TOV_COND_BLOCKED 3'h5

// load status codes
`define TOV_LOAD_LIGHT 2'h0
`define TOV_LOAD_NORMAL 2'h1
`define TOV_LOAD_OVER 2'h2
`define TOV_LOAD_HIGH 2'h3

// node behaviour codes and mode selector values
`define TOV_NODE_ON 3'h0
`define TOV_NODE_BLOCKED 3'h1
`define TOV_NODE_TEST 3'h2
`define TOV_NODE_TEST_BLK 3'h3
`define TOV_NODE_OFF 3'h4
`define TOV_MODE_ON 2'h0
`define TOV_MODE_TEST 2'h1

// event index: alarm 1, alarm 2, inhibit, trip, block
`define TOV_NEVT 5
`define TOV_EVT_BLK 4

`endif

// ===== core/tov_evt.v
/*
 * One output's edge detector and resettable activation counter.
 * Assumes a level that only changes on the system clock.
 */
`timescale 1ns/1ps
module tov_evt #(
   parameter CNT_W = 16
) (
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_lvl,
   input wire i_clr,
   output reg o_on,
   output reg o_off,
   output reg [CNT_W-1:0] o_cnt
);
   reg lvl_r;

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         lvl_r <= 1'b0;
         o_on <= 1'b0;
         o_off <= 1'b0;
         o_cnt <= {CNT_W{1'b0}};
      end else begin
         lvl_r <= i_lvl;
         o_on <= i_lvl & ~lvl_r; // R18
         o_off <= ~i_lvl & lvl_r; // R18
         // a clear in the same cycle as an activation keeps that activation
         if (i_clr)
            o_cnt <= {{(CNT_W-1){1'b0}}, i_lvl & ~lvl_r}; // R17
         else if (i_lvl & ~lvl_r & ~(&o_cnt))
            o_cnt <= o_cnt + 1'b1; // R17
      end
   end
endmodule // tov_evt

// ===== core/tov_top.v
/*
 * Thermal overload decision logic: alarm, inhibit and delayed trip outputs,
 * blocking, condition, load and setting fault reports, counters, events.
 * Assumes thermal capacity and current are computed upstream and are
 * synchronous to i_sys_clk; registers are reached over classic Wishbone.
 */
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "tov_regs.vh"
module tov_top #(
   parameter CLK_PERIOD_NS = `TOV_CLK_PERIOD_NS,
   parameter CYCLE_NS = `TOV_CYCLE_NS,
   parameter TICK_CYC = CYCLE_NS / CLK_PERIOD_NS,
   parameter CNT_W = 16
) (
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [7:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   input wire [11:0] i_theta,
   input wire [15:0] i_current,
   input wire [15:0] i_pickup_current,
   input wire i_block,
   input wire [15:0] i_service_factor,
   input wire i_service_factor_bad,
   input wire [15:0] i_amb_k,
   input wire i_amb_bad,
   input wire i_amb_k_inconsistent,
   input wire [15:0] i_nom_current,
   input wire i_nom_current_bad,
   output reg [15:0] o_service_factor,
   output reg [15:0] o_amb_k,
   output reg [15:0] o_nom_current,
   output reg o_alarm1,
   output reg o_alarm2,
   output reg o_inhibit,
   output reg o_trip,
   output reg o_start,
   output reg o_blocked,
   output reg [2:0] o_condition,
   output reg [1:0] o_load_status,
   output reg [3:0] o_setting_fault,
   output reg [2:0] o_node_behaviour,
   output reg o_node_visible,
   output reg [4:0] o_evt_on,
   output reg [4:0] o_evt_off,
   output reg [31:0] o_evt_time,
   output reg o_irq
);
   localparam TICK_W = 32;
   localparam [TICK_W-1:0] TICK_LAST = TICK_CYC - 1;

   reg [31:0] ctrl_r;
   reg [11:0] a1_lvl_r;
   reg [11:0] a2_lvl_r;
   reg [11:0] inh_lvl_r;
   reg [11:0] trip_lvl_r;
   reg [19:0] trip_dly_r;
   reg [9:0] irq_stat_r;
   reg [9:0] irq_mask_r;
   reg [4:0] cnt_clr_r;
   reg [TICK_W-1:0] tick_cnt_r;
   reg tick_r;
   reg [31:0] time_r;
   reg blk_s_r;
   reg pick_r;
   reg [19:0] dly_cnt_r;
   reg [31:0] rd_nxt;
   reg [2:0] cond_nxt;
   reg [1:0] load_nxt;
   reg [2:0] node_nxt;

   wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire wb_wr = wb_req & i_wb_we;
   wire [31:0] wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
   wire [31:0] wdat_ctrl = (ctrl_r & ~wmask) | (i_wb_dat & wmask);
   wire [4:0] lvl = {o_blocked, o_trip, o_inhibit, o_alarm2, o_alarm1};
   wire [4:0] on_p;
   wire [4:0] off_p;
   wire [CNT_W-1:0] cnt [0:`TOV_NEVT-1];
   wire [9:0] evt_set = {off_p & {5{ctrl_r[`TOV_CTRL_EVT_OFF]}}, on_p & {5{ctrl_r[`TOV_CTRL_EVT_ON]}}}; // R18
   wire pick_now = i_theta >= trip_lvl_r; // R19
   wire [1:0] mode = ctrl_r[`TOV_CTRL_MODE_HI:`TOV_CTRL_MODE_LO];

   // program cycle tick
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         tick_cnt_r <= {TICK_W{1'b0}};
         tick_r <= 1'b0;
         time_r <= 32'h0000_0000;
      end else begin
         tick_r <= (tick_cnt_r == TICK_LAST);
         if (tick_cnt_r == TICK_LAST)
            tick_cnt_r <= {TICK_W{1'b0}};
         else
            tick_cnt_r <= tick_cnt_r + 1'b1;
         if (tick_r)
            time_r <= time_r + 32'h0000_0001;
      end
   end

   // once-per-cycle evaluation of thresholds, blocking and trip delay
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         blk_s_r <= 1'b0;
         pick_r <= 1'b0;
         dly_cnt_r <= 20'h0_0000;
         o_alarm1 <= 1'b0;
         o_alarm2 <= 1'b0;
         o_inhibit <= 1'b0;
         o_trip <= 1'b0;
         o_start <= 1'b0;
         o_blocked <= 1'b0;
      end else if (tick_r) begin
         blk_s_r <= i_block; // R5
         // the delay counts whole cycles, so a block must lead expiry by one cycle
         o_alarm1 <= ctrl_r[`TOV_CTRL_EN_A1] & (i_theta >= a1_lvl_r) & ~i_block; // R1 R19
         o_alarm2 <= ctrl_r[`TOV_CTRL_EN_A2] & (i_theta >= a2_lvl_r) & ~i_block; // R2 R19
         o_inhibit <= ctrl_r[`TOV_CTRL_EN_INH] & (i_theta >= inh_lvl_r) & ~i_block; // R3 R19
         pick_r <= pick_now;
         if (!pick_now) begin
            o_start <= 1'b0;
            o_blocked <= 1'b0;
            o_trip <= 1'b0;
            dly_cnt_r <= 20'h0_0000;
         end else if (i_block) begin
            if (!o_start)
               o_blocked <= ~pick_r | o_blocked; // R7
            o_start <= 1'b0; // R8
            o_trip <= 1'b0; // R8
            dly_cnt_r <= 20'h0_0000; // R8
         end else if (!o_blocked) begin
            o_start <= 1'b1; // R6
            if (dly_cnt_r >= trip_dly_r)
               o_trip <= 1'b1; // R4
            else
               dly_cnt_r <= dly_cnt_r + 20'h0_0001; // R4
         end else begin
            o_blocked <= 1'b1; // R7
         end
      end
   end

   // condition, load and node behaviour
   always @* begin
      if (o_blocked)
         cond_nxt = `TOV_COND_BLOCKED; // R10
      else if (o_trip)
         cond_nxt = `TOV_COND_TRIP; // R10
      else if (o_inhibit)
         cond_nxt = `TOV_COND_INH; // R10
      else if (o_alarm2)
         cond_nxt = `TOV_COND_A2; // R10
      else if (o_alarm1)
         cond_nxt = `TOV_COND_A1; // R10
      else
         cond_nxt = `TOV_COND_NORMAL; // R10
      if (i_current < `TOV_LIGHT_LOAD)
         load_nxt = `TOV_LOAD_LIGHT; // R11
      else if (i_current > `TOV_HIGH_LOAD)
         load_nxt = `TOV_LOAD_HIGH; // R11
      else if (i_current > i_pickup_current)
         load_nxt = `TOV_LOAD_OVER; // R11
      else
         load_nxt = `TOV_LOAD_NORMAL; // R11
      case (mode)
         `TOV_MODE_ON: node_nxt = blk_s_r ? `TOV_NODE_BLOCKED : `TOV_NODE_ON; // R16
         `TOV_MODE_TEST: node_nxt = blk_s_r ? `TOV_NODE_TEST_BLK : `TOV_NODE_TEST; // R16
         default: node_nxt = `TOV_NODE_OFF; // R16
      endcase
   end

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_condition <= `TOV_COND_NORMAL;
         o_load_status <= `TOV_LOAD_LIGHT;
         o_node_behaviour <= `TOV_NODE_OFF;
         o_node_visible <= 1'b0;
         o_setting_fault <= 4'h0;
         o_service_factor <= `TOV_UNITY;
         o_amb_k <= `TOV_UNITY;
         o_nom_current <= `TOV_UNITY;
      end else begin
         o_condition <= cond_nxt;
         o_load_status <= load_nxt;
         o_node_visible <= ctrl_r[`TOV_CTRL_ALLOW_NODE]; // R16
         o_node_behaviour <= ctrl_r[`TOV_CTRL_ALLOW_NODE] ? node_nxt : `TOV_NODE_OFF; // R16
         o_setting_fault <= {i_amb_k_inconsistent, i_nom_current_bad, i_amb_bad, i_service_factor_bad}; // R12 R13 R14 R15
         o_service_factor <= i_service_factor_bad ? `TOV_UNITY : i_service_factor; // R12
         o_amb_k <= i_amb_bad ? `TOV_UNITY : i_amb_k; // R13
         o_nom_current <= i_nom_current_bad ? `TOV_UNITY : i_nom_current; // R14
      end
   end

   // edge detection and counters per output
   genvar g;
   generate
      for (g = 0; g < `TOV_NEVT; g = g + 1) begin : g_evt
         tov_evt #(
            .CNT_W(CNT_W)
         ) u_evt (
            .i_sys_clk(i_sys_clk),
            .i_rst(i_rst),
            .i_lvl(lvl[g]),
            .i_clr(cnt_clr_r[g]),
            .o_on(on_p[g]),
            .o_off(off_p[g]),
            .o_cnt(cnt[g])
         );
      end
   endgenerate

   // event outputs and time stamp of the latest stored event
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_evt_on <= 5'h00;
         o_evt_off <= 5'h00;
         o_evt_time <= 32'h0000_0000;
      end else begin
         o_evt_on <= evt_set[4:0]; // R18
         o_evt_off <= evt_set[9:5]; // R18
         if (|evt_set)
            o_evt_time <= time_r; // R18
      end
   end

   // register read mux
   always @* begin
      rd_nxt = 32'h0000_0000;
      case (i_wb_adr)
         `TOV_ADR_CTRL: rd_nxt = ctrl_r;
         `TOV_ADR_A1_LVL: rd_nxt = {20'h0_0000, a1_lvl_r};
         `TOV_ADR_A2_LVL: rd_nxt = {20'h0_0000, a2_lvl_r};
         `TOV_ADR_INH_LVL: rd_nxt = {20'h0_0000, inh_lvl_r};
         `TOV_ADR_TRIP_LVL: rd_nxt = {20'h0_0000, trip_lvl_r};
         `TOV_ADR_TRIP_DLY: rd_nxt = {12'h000, trip_dly_r};
         `TOV_ADR_STATUS: rd_nxt = {12'h000, o_node_visible, o_node_behaviour, o_setting_fault,
            o_blocked, o_start, o_trip, o_inhibit, o_alarm2, o_alarm1, o_load_status, 1'b0, o_condition};
         `TOV_ADR_IRQ_STAT: rd_nxt = {22'h00_0000, irq_stat_r};
         `TOV_ADR_IRQ_MASK: rd_nxt = {22'h00_0000, irq_mask_r};
         `TOV_ADR_CNT_BASE: rd_nxt = {{(32-CNT_W){1'b0}}, cnt[0]};
         `TOV_ADR_CNT_BASE + 8'h04: rd_nxt = {{(32-CNT_W){1'b0}}, cnt[1]};
         `TOV_ADR_CNT_BASE + 8'h08: rd_nxt = {{(32-CNT_W){1'b0}}, cnt[2]};
         `TOV_ADR_CNT_BASE + 8'h0C: rd_nxt = {{(32-CNT_W){1'b0}}, cnt[3]};
         `TOV_ADR_CNT_BASE + 8'h10: rd_nxt = {{(32-CNT_W){1'b0}}, cnt[4]};
         `TOV_ADR_TSTAMP: rd_nxt = o_evt_time;
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
         ctrl_r <= `TOV_CTRL_RST;
         a1_lvl_r <= `TOV_A1_LVL_RST;
         a2_lvl_r <= `TOV_A2_LVL_RST;
         inh_lvl_r <= `TOV_INH_LVL_RST;
         trip_lvl_r <= `TOV_TRIP_LVL_RST;
         trip_dly_r <= `TOV_TRIP_DLY_RST;
         irq_stat_r <= 10'h000;
         irq_mask_r <= 10'h000;
         cnt_clr_r <= 5'h00;
         o_irq <= 1'b0;
      end else begin
         o_wb_ack <= wb_req;
         if (wb_req)
            o_wb_dat <= rd_nxt;
         cnt_clr_r <= 5'h00;
         if (wb_wr) begin
            case (i_wb_adr)
               `TOV_ADR_CTRL: ctrl_r <= wdat_ctrl;
               `TOV_ADR_A1_LVL: a1_lvl_r <= i_wb_dat[11:0]; // R1
               `TOV_ADR_A2_LVL: a2_lvl_r <= i_wb_dat[11:0]; // R2
               `TOV_ADR_INH_LVL: inh_lvl_r <= i_wb_dat[11:0]; // R3
               `TOV_ADR_TRIP_LVL: trip_lvl_r <= i_wb_dat[11:0]; // R4
               `TOV_ADR_TRIP_DLY: trip_dly_r <= (i_wb_dat[19:0] > `TOV_TRIP_DLY_MAX) ?
                  `TOV_TRIP_DLY_MAX : i_wb_dat[19:0]; // R4
               `TOV_ADR_IRQ_MASK: irq_mask_r <= i_wb_dat[9:0];
               `TOV_ADR_CNT_CLR: cnt_clr_r <= i_wb_dat[4:0]; // R17
               default: cnt_clr_r <= 5'h00;
            endcase
         end
         // a new event wins over a write-one clear in the same cycle
         if (wb_wr && i_wb_adr == `TOV_ADR_IRQ_STAT)
            irq_stat_r <= (irq_stat_r & ~i_wb_dat[9:0]) | evt_set;
         else
            irq_stat_r <= irq_stat_r | evt_set;
         o_irq <= |(irq_stat_r & irq_mask_r);
      end
   end
endmodule // tov_top

// ===== bench/tov_props.sv
/*
 * Checker of the thermal overload decision block, bound to its top.
 * Assumes one clock domain and the synchronous active-high reset.
 */
`timescale 1ns/1ps
module tov_props (
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire o_wb_ack,
   input wire [15:0] i_service_factor,
   input wire i_service_factor_bad,
   input wire i_amb_bad,
   input wire i_amb_k_inconsistent,
   input wire i_nom_current_bad,
   input wire [15:0] o_service_factor,
   input wire [15:0] o_amb_k,
   input wire [15:0] o_nom_current,
   input wire o_trip,
   input wire o_start,
   input wire o_blocked,
   input wire [2:0] o_condition,
   input wire [3:0] o_setting_fault,
   input wire [2:0] o_node_behaviour,
   input wire o_node_visible
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   a_wb_ack_pulse: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
      else $error("ack not a single pulse one cycle after request");
   a_trip_needs_start: assert property (o_trip |-> o_start) else $error("trip without start");
   a_start_blk_excl: assert property (!(o_start && o_blocked)) else $error("start with blocked");
   a_trip_cond: assert property ($rose(o_trip) |=> o_condition == 3'h4)
      else $error("trip condition code wrong");
   a_blk_cond: assert property ($rose(o_blocked) |=> o_condition == 3'h5)
      else $error("blocked condition code wrong");
   a_sf_override: assert property (i_service_factor_bad |=> o_setting_fault[0] && o_service_factor == 16'h0064)
      else $error("service factor override missing");
   a_sf_pass: assert property (!i_service_factor_bad |=> !o_setting_fault[0] &&
      o_service_factor == $past(i_service_factor)) else $error("service factor not passed");
   a_amb_override: assert property (i_amb_bad |=> o_setting_fault[1] && o_amb_k == 16'h0064)
      else $error("ambient override missing");
   a_nom_override: assert property (i_nom_current_bad |=> o_setting_fault[2] && o_nom_current == 16'h0064)
      else $error("nominal current override missing");
   a_amb_incons: assert property (o_setting_fault[3] == $past(i_amb_k_inconsistent))
      else $error("ambient k fault flag wrong");
   a_node_hidden: assert property (!o_node_visible |-> o_node_behaviour == 3'h4)
      else $error("node behaviour shown while hidden");
   c_trip: cover property ($rose(o_trip));
   c_blocked: cover property ($rose(o_blocked));
   c_sf_fault: cover property (o_setting_fault[0]);
endmodule // tov_props
bind tov_top tov_props u_props (.*);

// ===== bench/tov_img.sv
/*
 * Model of the thermal image calculator and blocking matrix feeding the block.
 * Assumes the bench sets the wanted capacity and block request on the clock.
 */
`timescale 1ns/1ps
module tov_img (
   input wire i_sys_clk,
   input wire [11:0] i_theta_req,
   input wire i_blk_req,
   output reg [11:0] o_theta,
   output reg o_block
);
   initial begin
      o_theta = 12'h000;
      o_block = 1'b0;
   end
   // registered so block reaches the block one cycle after the request, well ahead of any delay end
   always @(posedge i_sys_clk) begin
      o_theta <= i_theta_req;
      o_block <= i_blk_req;
   end
endmodule // tov_img

// ===== bench/tb_thermal_overload_alarm_trip.sv
/*
 * Self-checking bench of the thermal overload decision block.
 * Assumes a program cycle of 20 clocks (CYCLE_NS 100) and a 1-cycle Wishbone ack.
 */
`timescale 1ns/1ps
module tb_thermal_overload_alarm_trip;
   localparam int TK = 20;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, blk = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rd, q;
   logic [11:0] th = 12'h000, theta;
   logic [15:0] cur = 16'h0000, fv = 16'h0050;
   logic [3:0] bad = 4'h0;
   logic ack, block, a1, a2, inh, trip, start, blkd, vis, irq;
   logic [2:0] cond, node;
   logic [1:0] load;
   logic [3:0] flt;
   logic [15:0] sf;
   int n_mismatch = 0, num_checks = 0;
   always #2.5 clk = ~clk;
   tov_img u_img (.i_sys_clk(clk), .i_theta_req(th), .i_blk_req(blk), .o_theta(theta), .o_block(block));
   tov_top #(.CYCLE_NS(100)) DUT (.i_sys_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wd), .o_wb_dat(rd), .o_wb_ack(ack), .i_theta(theta),
      .i_current(cur), .i_pickup_current(16'h0069), .i_block(block), .i_service_factor(fv),
      .i_service_factor_bad(bad[0]), .i_amb_k(fv), .i_amb_bad(bad[1]), .i_amb_k_inconsistent(bad[3]),
      .i_nom_current(fv), .i_nom_current_bad(bad[2]), .o_service_factor(sf), .o_amb_k(), .o_nom_current(),
      .o_alarm1(a1), .o_alarm2(a2), .o_inhibit(inh), .o_trip(trip), .o_start(start), .o_blocked(blkd),
      .o_condition(cond), .o_load_status(load), .o_setting_fault(flt), .o_node_behaviour(node),
      .o_node_visible(vis), .o_evt_on(), .o_evt_off(), .o_evt_time(), .o_irq(irq));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = rd;
      cyc <= 0; stb <= 0;
      if (k >= 50) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   task automatic ticks(input int n);
      repeat (n * TK + 4) @(posedge clk);
   endtask
   task automatic wait_start();
      int k;
      for (k = 0; k < 100 && start !== 1'b1; k++) @(posedge clk);
      if (k >= 100) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      wb(0, 8'h00, 0); chk("ctrl reset", 32'h0000_0300, q);
      wb(0, 8'h04, 0); chk("a1 level reset", 32'h0000_0190, q);
      wb(0, 8'h0C, 0); chk("inh level reset", 32'h0000_0320, q);
      wb(0, 8'h10, 0); chk("trip level reset", 32'h0000_03E8, q);
      wb(0, 8'h40, 0); chk("unmapped", 32'h0000_0000, q);
      wb(1, 8'h00, 32'h0000_0318); repeat (3) @(posedge clk);
      chk("node test", {vis, node}, {1'b1, 3'h2});
      $display("test reset and registers done");
      @(posedge clk); th <= 12'h384; cur <= 16'h00FA; bad <= 4'hF;
      ticks(2);
      chk("outputs disabled", {a1, a2, inh, trip}, 4'h0);
      chk("load high", load, 2'h3);
      chk("faults", {flt, sf}, {4'hF, 16'h0064});
      wb(1, 8'h00, 32'h0000_0307); ticks(2);
      chk("node hidden", {vis, node}, {1'b0, 3'h4});
      chk("alarms on", {a1, a2, inh, trip}, 4'hE);
      @(posedge clk); th <= 12'h320; bad <= 4'h0; ticks(2);
      chk("inhibit at level", inh, 1'b1);
      chk("sf restored", {flt, sf}, {4'h0, fv});
      @(posedge clk); th <= 12'h31F; ticks(2);
      chk("inhibit below level", {a1, inh}, 2'h2);
      $display("test alarm thresholds done");
      wb(1, 8'h14, 32'h0000_0002); wb(1, 8'h1C, 32'h0000_03FF); wb(1, 8'h20, 32'h0000_0000);
      @(posedge clk); th <= 12'h3E8; cur <= 16'h0096;
      wait_start();
      // start and the first delay count share one tick, so trip lands two ticks after start
      repeat (2 * TK - 1) @(posedge clk);
      chk("trip early", trip, 1'b0);
      @(posedge clk); chk("trip after delay", trip, 1'b1);
      @(posedge clk); chk("cond trip", cond, 3'h4);
      chk("load over", load, 2'h2);
      wb(0, 8'h1C, 0); chk("irq status", q, 32'h0000_000C);
      chk("irq masked", irq, 1'b0);
      wb(1, 8'h20, 32'h0000_0008); repeat (2) @(posedge clk); chk("irq on", irq, 1'b1);
      wb(1, 8'h1C, 32'h0000_0008); repeat (2) @(posedge clk); chk("irq cleared", irq, 1'b0);
      wb(0, 8'h34, 0); chk("trip count", q, 32'h0000_0001);
      wb(1, 8'h24, 32'h0000_0008); wb(0, 8'h34, 0); chk("trip count clr", q, 32'h0000_0000);
      $display("test trip delay done");
      @(posedge clk); blk <= 1; ticks(2);
      chk("block after start", {start, trip, blkd}, 3'h0);
      @(posedge clk); th <= 12'h000; cur <= 16'h0000; ticks(2);
      chk("load light", load, 2'h0);
      @(posedge clk); th <= 12'h3E8; ticks(2);
      chk("blocked pickup", {start, blkd, cond}, {2'b01, 3'h5});
      wb(0, 8'h38, 0); chk("blocked count", q, 32'h0000_0001);
      wb(0, 8'h1C, 0); chk("irq off events", q, 32'h0000_01F4);
      $display("test blocking done");
      complete_run();
   end
endmodule // tb_thermal_overload_alarm_trip
